/* File: core/iehs_top.sv */
// serial eeprom host sequencer: command crossing, bus engine, read buffer
`timescale 1ns/10ps
module iehs_top #(
   parameter logic [17:0] P_TMO_CYC = iehs_pkg::TMO_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_link_clk,
   input wire logic i_size_strap,
   input wire logic i_cmd_valid,
   input wire logic i_cmd_write,
   input wire logic [iehs_pkg::ADDR_W-1:0] i_cmd_addr,
   input wire logic [iehs_pkg::DATA_W-1:0] i_cmd_wdata,
   input wire logic [iehs_pkg::LEN_W-1:0] i_cmd_len,
   output logic o_cmd_ready,
   output logic o_done,
   output logic o_timeout,
   input wire logic i_timeout_clr,
   output logic o_rd_valid,
   output logic [iehs_pkg::DATA_W-1:0] o_rd_data,
   input wire logic i_rd_ready,
   input wire logic i_scl,
   output logic o_scl,
   output logic o_scl_oe_n,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe_n
);
   import iehs_pkg::*;

   typedef struct packed {
      logic rdy;
      logic cmd_t;
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdat;
      logic [LEN_W-1:0] len;
      logic done_s;
      logic ack_t;
      logic tmo;
      logic done;
   } iehs_core_t;

   typedef struct packed {
      iehs_bus_t st;
      logic [1:0] ph;
      logic [5:0] cnt;
      logic [3:0] bit_n;
      logic [7:0] sh;
      logic samp;
      iehs_kind_t kind;
      logic fin;
      logic err;
      logic repoll;
      logic wr;
      logic strap;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdat;
      logic [LEN_W-1:0] left;
      logic [17:0] stc;
      logic [17:0] ptc;
      logic ptr;
      logic cmd_s;
      logic done_t;
      logic rx_t;
      logic [DATA_W-1:0] rx_d;
      logic scl_oe_n;
      logic sda_oe_n;
      logic lo;
   } iehs_link_t;

   iehs_core_t cq;
   iehs_core_t cd;
   iehs_link_t lq;
   iehs_link_t ld;
   logic [1:0] csync_q;
   logic [5:0] lsync_q;
   logic done_y;
   logic rx_y;
   logic lrst;
   logic cmd_y;
   logic ack_y;
   logic scl_y;
   logic sda_y;
   logic strap_y;
   logic [5:0] lim;
   logic busy_st;
   logic wait_ph;
   logic stall;
   logic stretch_to;
   logic step;
   logic bend;
   logic rx_k;
   logic drv;
   logic expired;
   logic done_ev;

   iehs_stream_if #(.W(DATA_W)) sif ();

   iehs_sync #(.W(2)) u_csync (
      .i_clk(i_core_clk),
      .i_d({lq.done_t, lq.rx_t}),
      .o_q(csync_q)
   );
   iehs_sync #(.W(6)) u_lsync (
      .i_clk(i_link_clk),
      .i_d({i_sys_rst, cq.cmd_t, cq.ack_t, i_scl, i_sda, i_size_strap}),
      .o_q(lsync_q)
   );
   iehs_fifo #(.W(DATA_W), .D(FIFO_D)) u_fifo (
      .i_clk(i_core_clk),
      .i_rst(i_sys_rst),
      .s_in(sif.snk),
      .o_valid(o_rd_valid),
      .o_data(o_rd_data),
      .i_ready(i_rd_ready)
   );

   assign done_y = csync_q[1];
   assign rx_y = csync_q[0];
   assign lrst = lsync_q[5];
   assign cmd_y = lsync_q[4];
   assign ack_y = lsync_q[3];
   assign scl_y = lsync_q[2];
   assign sda_y = lsync_q[1];
   assign strap_y = lsync_q[0];

   // core side: command capture, done return, read bytes into the fifo
   assign done_ev = done_y != cq.done_s;
   // byte is held by the engine until the ack toggle returns
   assign sif.valid = rx_y != cq.ack_t;
   assign sif.data = lq.rx_d;

   always_comb begin
      cd = cq;
      cd.done = 1'b0;
      if (cq.rdy && i_cmd_valid) begin
         cd.rdy = 1'b0;
         cd.cmd_t = ~cq.cmd_t;
         cd.wr = i_cmd_write;
         cd.addr = i_cmd_addr;
         cd.wdat = i_cmd_wdata;
         cd.len = i_cmd_len;
      end
      if (sif.valid && sif.ready) begin
         cd.ack_t = ~cq.ack_t;
      end
      if (done_ev) begin
         cd.done_s = done_y;
         cd.rdy = 1'b1;
         cd.done = 1'b1;
      end
      // a new timeout outranks a clear in the same cycle
      cd.tmo = (cq.tmo && !i_timeout_clr) || (done_ev && lq.err);
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         cq <= '{rdy: 1'b1, default: '0};
      end else begin
         cq <= cd;
      end
   end

   assign o_cmd_ready = cq.rdy;
   assign o_done = cq.done;
   assign o_timeout = cq.tmo;

   // link side: bit timing
   function automatic logic [7:0] load_byte(input iehs_kind_t k,
         input logic s, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] w);
      logic [2:0] sel;
      sel = (s || k == K_POLL) ? SEL_LOW : a[10:8];
      unique case (k)
         K_CTRLW, K_POLL: load_byte = {CTRL_CODE, sel, DIR_WR};
         K_CTRLR: load_byte = {CTRL_CODE, sel, DIR_RD};
         K_AHI: load_byte = a[15:8];
         K_ALO: load_byte = a[7:0];
         K_DATA: load_byte = w;
         K_RX: load_byte = 8'hFF;
      endcase
   endfunction

   // phase lengths keep the clock under rate
   always_comb begin
      unique case (lq.ph)
         2'h0: lim = HD_CYC;
         2'h1: lim = PH_CYC - HD_CYC;
         2'h2: lim = PH_CYC;
         2'h3: lim = (lq.st == B_STOP) ? BUF_CYC : PH_CYC;
      endcase
   end

   assign busy_st = lq.st == B_BYTE || lq.st == B_START || lq.st == B_STOP;
   assign wait_ph = busy_st && lq.ph == 2'h2;
   // no progress while the clock is held low
   assign stall = wait_ph && !scl_y;
   assign stretch_to = stall && lq.stc >= P_TMO_CYC;
   assign step = busy_st && !stall && lq.cnt == lim - 6'h01;
   assign bend = step && lq.st == B_BYTE && lq.ph == 2'h2 &&
      lq.bit_n == ACK_BIT;
   assign rx_k = lq.kind == K_RX;
   // ack every byte but the last
   assign drv = (lq.bit_n == ACK_BIT) ? (!rx_k || lq.left == '0) :
      (rx_k || lq.sh[7]);
   assign expired = lq.ptc >= P_TMO_CYC;

   always_comb begin
      iehs_kind_t nk;
      nk = lq.kind;
      ld = lq;
      ld.lo = 1'b0;
      if (lq.ptr && !expired) begin
         ld.ptc = lq.ptc + 18'h1;
      end
      ld.stc = stall ? lq.stc + 18'h1 : 18'h0;
      if (busy_st && !stall) begin
         ld.cnt = lq.cnt + 6'h01;
      end
      if (wait_ph && !stall && lq.cnt == 6'h00) begin
         ld.samp = sda_y;
      end
      if (step) begin
         ld.cnt = 6'h00;
         ld.ph = lq.ph + 2'h1;
         unique case (lq.ph)
            2'h0: ld.sda_oe_n = (lq.st == B_BYTE) ? drv : (lq.st == B_START);
            2'h1: ld.scl_oe_n = 1'b1;
            2'h2: begin
               ld.sda_oe_n = (lq.st == B_BYTE) ? lq.sda_oe_n :
                  (lq.st == B_STOP);
               if (lq.st == B_BYTE) begin
                  ld.scl_oe_n = 1'b0;
                  ld.ph = 2'h0;
                  // msb first, one bit per pulse
                  if (lq.bit_n != ACK_BIT) begin
                     ld.bit_n = lq.bit_n + 4'h1;
                     ld.sh = {lq.sh[6:0], lq.samp};
                  end
               end
            end
            2'h3: ld.scl_oe_n = (lq.st == B_START) ? 1'b0 : lq.scl_oe_n;
         endcase
      end
      if (step && lq.st == B_START && lq.ph == 2'h3) begin
         ld.bit_n = 4'h0;
         if (lq.fin) begin
            ld.st = B_STOP;
         end else begin
            ld.st = B_BYTE;
            ld.sh = load_byte(lq.kind, lq.strap, lq.addr, lq.wdat);
         end
      end
      if (step && lq.st == B_STOP && lq.ph == 2'h3) begin
         // bus free time elapsed before the poll
         if (lq.repoll) begin
            ld.st = B_START;
            ld.repoll = 1'b0;
            ld.kind = K_POLL;
         end else begin
            ld.st = B_IDLE;
            ld.ptr = 1'b0;
            ld.done_t = ~lq.done_t;
         end
      end
      if (bend) begin
         ld.bit_n = 4'h0;
         if (rx_k) begin
            ld.st = B_PUSH;
            ld.rx_d = lq.sh;
            ld.rx_t = ~lq.rx_t;
         end else if (lq.samp) begin
            // timeout looked at only after a poll nack
            if (lq.kind == K_POLL && !expired) begin
               ld.st = B_STOP;
               ld.repoll = 1'b1;
            end else begin
               ld.st = B_START;
               ld.fin = 1'b1;
               ld.err = 1'b1;
            end
         end else begin
            case (lq.kind)
               K_CTRLW: nk = lq.strap ? K_AHI : K_ALO;
               K_AHI: nk = K_ALO;
               K_ALO: begin
                  if (lq.wr) begin
                     nk = K_DATA;
                  end else begin
                     nk = K_CTRLR;
                     ld.st = B_START;
                  end
               end
               K_CTRLR: nk = K_RX;
               K_DATA: begin
                  ld.st = B_STOP;
                  ld.repoll = 1'b1;
                  ld.ptr = 1'b1;
                  ld.ptc = 18'h0;
               end
               K_POLL: begin
                  ld.st = B_START;
                  ld.fin = 1'b1;
               end
               default: nk = lq.kind;
            endcase
            ld.kind = nk;
            ld.sh = load_byte(nk, lq.strap, lq.addr, lq.wdat);
         end
      end
      if (lq.st == B_PUSH && ack_y == lq.rx_t) begin
         if (lq.left == '0) begin
            ld.st = B_STOP;
         end else begin
            ld.left = lq.left - 1'b1;
            ld.st = B_BYTE;
            ld.sh = 8'hFF;
         end
      end
      if (lq.st == B_IDLE && cmd_y != lq.cmd_s) begin
         ld.cmd_s = cmd_y;
         ld.st = B_START;
         ld.ph = 2'h0;
         ld.cnt = 6'h00;
         ld.kind = K_CTRLW;
         ld.fin = 1'b0;
         ld.err = 1'b0;
         ld.repoll = 1'b0;
         ld.ptr = 1'b0;
         ld.wr = cq.wr;
         ld.addr = cq.addr;
         ld.wdat = cq.wdat;
         ld.left = cq.len;
         ld.strap = strap_y;
      end
      // release both lines, no start or stop
      if (stretch_to) begin
         ld.st = B_IDLE;
         ld.ph = 2'h0;
         ld.cnt = 6'h00;
         ld.scl_oe_n = 1'b1;
         ld.sda_oe_n = 1'b1;
         ld.err = 1'b1;
         ld.ptr = 1'b0;
         ld.done_t = ~lq.done_t;
      end
   end

   always_ff @(posedge i_link_clk) begin
      if (lrst) begin
         lq <= '{st: B_IDLE, kind: K_CTRLW, scl_oe_n: 1'b1,
            sda_oe_n: 1'b1, default: '0};
      end else begin
         lq <= ld;
      end
   end

   assign o_scl = lq.lo;
   assign o_sda = lq.lo;
   assign o_scl_oe_n = lq.scl_oe_n;
   assign o_sda_oe_n = lq.sda_oe_n;

   default clocking @(posedge i_link_clk); endclocking
   default disable iff (lrst);

   sequence s_abort;
      (lq.st == B_START && lq.fin && lq.err) ##[100:900] (lq.st == B_STOP);
   endsequence

   chk_ctrl_code: assert property (
      (lq.st == B_START && ld.st == B_BYTE) |=>
      lq.sh[7:4] == CTRL_CODE && lq.sh[0] == (lq.kind == K_CTRLR))
      else $error("control code or direction wrong");
   chk_sel_bits: assert property (
      (lq.st == B_START && ld.st == B_BYTE) |=> lq.sh[3:1] ==
      ((lq.strap || lq.kind == K_POLL) ? SEL_LOW : lq.addr[10:8]))
      else $error("select bits wrong");
   chk_addr_len: assert property (
      (bend && !lq.samp && lq.kind == K_CTRLW) |=>
      lq.kind == (lq.strap ? K_AHI : K_ALO))
      else $error("address byte count wrong");
   chk_addr_full: assert property (
      (bend && !lq.samp && lq.kind == K_AHI) |=> lq.sh == lq.addr[7:0])
      else $error("low address byte wrong");
   chk_nack_abort: assert property (
      (bend && lq.samp && !rx_k && lq.kind != K_POLL) |=> s_abort)
      else $error("missing acknowledge not aborted");
   chk_poll_finish: assert property (
      (bend && !lq.samp && lq.kind == K_POLL) |=>
      lq.st == B_START && lq.fin && !lq.err)
      else $error("poll ack not finished by start and stop");
   chk_stretch_out: assert property (
      stretch_to |=> lq.st == B_IDLE && lq.scl_oe_n && lq.sda_oe_n &&
      lq.err && lq.done_t != $past(lq.done_t))
      else $error("stretch timeout did not release lines");
   chk_scl_wait: assert property (
      (stall && !stretch_to) |=>
      $stable(lq.ph) && $stable(lq.cnt) && lq.scl_oe_n)
      else $error("advanced while clock held low");
   chk_buf_time: assert property (
      (lq.st == B_STOP && lq.ph == 2'h3 && lq.cnt == 6'h00) |->
      ##37 (lq.st == B_STOP && lq.ph == 2'h3))
      else $error("bus free time too short");
   chk_msb_first: assert property (
      (step && lq.st == B_BYTE && lq.ph == 2'h0 && !rx_k &&
      lq.bit_n != ACK_BIT) |=> lq.sda_oe_n == $past(lq.sh[7]))
      else $error("bit order wrong");
   chk_rx_ack: assert property (
      (step && lq.st == B_BYTE && rx_k && lq.ph == 2'h0 &&
      lq.bit_n == ACK_BIT) |=> lq.sda_oe_n == ($past(lq.left) == '0))
      else $error("read acknowledge wrong");
endmodule

/* File: core/iehs_pkg.sv */
// constants and types shared by the serial eeprom host sequencer
package iehs_pkg;
   localparam int LINK_PERIOD_NS = 125;
   localparam int T_PHASE_NS = 5200;
   localparam int T_HD_DAT_NS = 1000;
   localparam int T_BUF_NS = 4700;
   localparam int T_TMO_MS = 30;
   localparam logic [5:0] PH_CYC =
      6'((T_PHASE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
   localparam logic [5:0] HD_CYC =
      6'((T_HD_DAT_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
   localparam logic [5:0] BUF_CYC =
      6'((T_BUF_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
   localparam logic [17:0] TMO_CYC =
      18'(T_TMO_MS * 1000000 / LINK_PERIOD_NS);
   localparam logic [3:0] CTRL_CODE = 4'hA;
   localparam logic [2:0] SEL_LOW = 3'h0;
   localparam logic DIR_WR = 1'b0;
   localparam logic DIR_RD = 1'b1;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int LEN_W = 8;
   localparam int FIFO_D = 4;
   typedef enum logic [4:0] {
      B_IDLE = 5'h01, B_START = 5'h02, B_BYTE = 5'h04,
      B_STOP = 5'h08, B_PUSH = 5'h10
   } iehs_bus_t;
   typedef enum logic [6:0] {
      K_CTRLW = 7'h01, K_AHI = 7'h02, K_ALO = 7'h04, K_CTRLR = 7'h08,
      K_DATA = 7'h10, K_POLL = 7'h20, K_RX = 7'h40
   } iehs_kind_t;
endpackage

/* File: core/iehs_stream_if.sv */
// valid/ready byte stream between the sequencer and its read buffer
`timescale 1ns/10ps
interface iehs_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* File: core/iehs_sync.sv */
// two flip-flop synchroniser for independent single-bit levels
`timescale 1ns/10ps
module iehs_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } iehs_sync_t;
   iehs_sync_t q;
   iehs_sync_t d;
   always_comb begin
      d.s1 = i_d;
      d.s2 = q.s1;
   end
   always_ff @(posedge i_clk) begin
      q <= d;
   end
   assign o_q = q.s2;
endmodule

/* File: core/iehs_fifo.sv */
// small read-data fifo with registered output stage
`timescale 1ns/10ps
module iehs_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input wire logic i_clk,
   input wire logic i_rst,
   iehs_stream_if.snk s_in,
   output logic o_valid,
   output logic [W-1:0] o_data,
   input wire logic i_ready
);
   // depth must be a power of two
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic ov;
      logic [W-1:0] od;
   } iehs_fifo_t;
   iehs_fifo_t q;
   iehs_fifo_t d;
   logic push;
   logic pop;
   assign s_in.ready = q.cnt != (AW + 1)'(D);
   assign push = s_in.valid && s_in.ready;
   assign pop = q.cnt != '0 && (!q.ov || i_ready);
   always_comb begin
      d = q;
      if (q.ov && i_ready) begin
         d.ov = 1'b0;
      end
      if (pop) begin
         d.ov = 1'b1;
         d.od = q.mem[q.rp];
         d.rp = q.rp + 1'b1;
      end
      if (push) begin
         d.mem[q.wp] = s_in.data;
         d.wp = q.wp + 1'b1;
      end
      if (push && !pop) begin
         d.cnt = q.cnt + 1'b1;
      end else if (pop && !push) begin
         d.cnt = q.cnt - 1'b1;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign o_valid = q.ov;
   assign o_data = q.od;
endmodule

/* File: testbench/iehs_eeprom_model.sv */
// behavioural serial eeprom client for the sequencer bench
`timescale 1ns/10ps
module iehs_eeprom_model (
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_two,
   input wire logic [31:0] i_nack_at,
   input wire logic [31:0] i_busy_polls,
   input wire logic [31:0] i_stretch_ns,
   output logic o_sda_lo,
   output logic o_scl_lo
);
   logic [7:0] mem [0:65535];
   logic [7:0] sh, hi, txb;
   logic [2:0] sel;
   logic [15:0] ptr;
   logic tx = 0, rdgo = 0, hack = 0, wrote = 0, live = 0, ack;
   int cnt = 0, nbyte = 0, busy = 0, n_ctl = 0;
   initial begin
      o_sda_lo = 0;
      o_scl_lo = 0;
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h3C;
      end
   end
   always @(negedge i_sda) begin
      if (i_scl) begin
         cnt = 0;
         nbyte = 0;
         tx = 0;
         live = 1;
      end
   end
   // busy time starts at the stop closing a write
   always @(posedge i_sda) begin
      if (i_scl) begin
         live = 0;
         if (wrote) begin
            busy = i_busy_polls;
         end
         wrote = 0;
      end
   end
   // msb first, one bit a pulse
   always @(posedge i_scl) begin
      cnt = cnt + 1;
      sh = {sh[6:0], i_sda};
      hack = !i_sda;
   end
   always @(negedge i_scl) begin
      if (live && cnt == 8 && tx) begin
         o_sda_lo = 0;
      end else if (live && cnt == 8) begin
         ack = 1;
         if (nbyte + 1 == i_nack_at) begin
            ack = 0;
         end else if (nbyte == 0) begin
            n_ctl++;
            sel = sh[3:1];
            ack = sh[7:4] == 4'hA && !(i_two && sel != 0) && busy == 0;
            busy = busy > 0 ? busy - 1 : 0;
            rdgo = ack & sh[0];
         end else if (nbyte == 1 && i_two) begin
            hi = sh;
         end else if (nbyte == 1 || (nbyte == 2 && i_two)) begin
            ptr = i_two ? {hi, sh} : {5'h0, sel, sh};
         end else begin
            mem[ptr] = sh;
            ptr++;
            wrote = 1;
         end
         nbyte++;
         o_sda_lo = ack;
         live = ack;
      end else if (live && cnt == 9) begin
         cnt = 0;
         tx = rdgo || (tx && hack);
         rdgo = 0;
         if (tx) begin
            txb = mem[ptr];
            ptr++;
         end
         o_sda_lo = tx && !txb[7];
         // stretch low phase, data line already settled
         if (i_stretch_ns != 0) begin
            o_scl_lo = 1;
            #(i_stretch_ns);
            o_scl_lo = 0;
         end
      end else if (live && tx && cnt < 8) begin
         o_sda_lo = !txb[7 - cnt];
      end
   end
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the serial eeprom host sequencer
`timescale 1ns/10ps
module tb_top;
   import iehs_pkg::*;
   logic i_core_clk = 0;
   logic i_link_clk = 0;
   logic i_sys_rst = 1;
   logic i_size_strap = 0;
   logic i_cmd_valid = 0;
   logic i_cmd_write = 0;
   logic [ADDR_W-1:0] i_cmd_addr = '0;
   logic [DATA_W-1:0] i_cmd_wdata = '0;
   logic [LEN_W-1:0] i_cmd_len = '0;
   logic i_timeout_clr = 0;
   logic i_rd_ready = 0;
   logic o_cmd_ready, o_done, o_timeout, o_rd_valid;
   logic [DATA_W-1:0] o_rd_data;
   logic o_scl, o_scl_oe_n, o_sda, o_sda_oe_n;
   logic m_sda_lo, m_scl_lo, scl_w, sda_w, rd_hold = 0;
   logic [31:0] nack_at = 0, busy_polls = 0, stretch_ns = 0;
   logic [7:0] exp_rd [$];
   logic exp_to [$];
   int err_total = 0;
   int samples_checked = 0;
   int cycles = 0;
   integer seed = 32'h9F7A61F4;
   always #2.5 i_core_clk = ~i_core_clk;
   // link clock offset so its edges never meet core edges
   initial begin
      #1.37;
      forever #62.5 i_link_clk = ~i_link_clk;
   end
   // pull-ups: a line is low while any party pulls it
   assign scl_w = (o_scl_oe_n | o_scl) & !m_scl_lo;
   assign sda_w = (o_sda_oe_n | o_sda) & !m_sda_lo;
   iehs_top #(.P_TMO_CYC(18'h00960)) dut (.i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst), .i_link_clk(i_link_clk),
      .i_size_strap(i_size_strap), .i_cmd_valid(i_cmd_valid),
      .i_cmd_write(i_cmd_write), .i_cmd_addr(i_cmd_addr),
      .i_cmd_wdata(i_cmd_wdata), .i_cmd_len(i_cmd_len),
      .o_cmd_ready(o_cmd_ready), .o_done(o_done), .o_timeout(o_timeout),
      .i_timeout_clr(i_timeout_clr), .o_rd_valid(o_rd_valid),
      .o_rd_data(o_rd_data), .i_rd_ready(i_rd_ready), .i_scl(scl_w),
      .o_scl(o_scl), .o_scl_oe_n(o_scl_oe_n), .i_sda(sda_w),
      .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n));
   iehs_eeprom_model eeprom (.i_scl(scl_w), .i_sda(sda_w),
      .i_two(i_size_strap), .i_nack_at(nack_at),
      .i_busy_polls(busy_polls), .i_stretch_ns(stretch_ns),
      .o_sda_lo(m_sda_lo), .o_scl_lo(m_scl_lo));
   function automatic logic [7:0] mem_val(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3C;
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic cmp_byte(input string nm, input logic [7:0] e,
         input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_flag(input string nm, input logic e, input logic g);
      cmp_byte(nm, {7'h0, e}, {7'h0, g});
   endtask
   task automatic run_cmd(input logic wr, input logic two,
         input logic [15:0] a, input logic [7:0] w, input logic [7:0] n,
         input logic to);
      exp_to.push_back(to);
      @(negedge i_core_clk);
      i_size_strap = two;
      i_cmd_write = wr;
      i_cmd_addr = a;
      i_cmd_wdata = w;
      i_cmd_len = n;
      repeat (400) @(negedge i_core_clk);
      i_cmd_valid = 1;
      @(posedge i_core_clk iff o_cmd_ready === 1'b1);
      @(negedge i_core_clk);
      i_cmd_valid = 0;
      @(posedge i_core_clk iff o_done === 1'b1);
      repeat (4) @(negedge i_core_clk);
      i_timeout_clr = 1;
      @(negedge i_core_clk);
      i_timeout_clr = 0;
   endtask
   always @(negedge i_core_clk) begin
      i_rd_ready <= !rd_hold && (($random(seed) & 3) != 0);
   end
   always @(posedge i_core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 1400000) begin
         err_total++;
         $display("mismatch run_length expected finish seen hang");
         complete_run();
      end
   end
   always @(posedge i_core_clk) begin
      if (o_rd_valid === 1'b1 && i_rd_ready === 1'b1) begin
         cmp_byte("rd_data", exp_rd.size() ? exp_rd.pop_front() : 8'hXX,
            o_rd_data);
      end
   end
   always @(posedge i_core_clk) begin
      if (o_done === 1'b1) begin
         @(posedge i_core_clk);
         cmp_flag("timeout", exp_to.pop_front(), o_timeout);
      end
   end
   initial begin
      logic [7:0] wd;
      int base;
      repeat (10) @(negedge i_link_clk);
      @(negedge i_core_clk);
      i_sys_rst = 0;
      repeat (200) @(negedge i_core_clk);
      wd = 8'($random(seed));
      base = eeprom.n_ctl;
      busy_polls = 1;
      run_cmd(1, 1, 16'hA5C3, wd, 8'h00, 0);
      cmp_byte("polls", 8'h03, 8'(eeprom.n_ctl - base));
      rd_hold = 1;
      fork
         #1200000 rd_hold = 0;
      join_none
      exp_rd.push_back(wd);
      for (int i = 1; i < 6; i++) begin
         exp_rd.push_back(mem_val(16'hA5C3 + 16'(i)));
      end
      run_cmd(0, 1, 16'hA5C3, 8'h00, 8'h05, 0);
      // longer than the host low time, so the engine really stalls
      stretch_ns = 9000;
      exp_rd.push_back(mem_val(16'h06E1));
      run_cmd(0, 0, 16'hF6E1, 8'h00, 8'h00, 0);
      stretch_ns = 0;
      nack_at = 2;
      run_cmd(0, 1, 16'h1234, 8'h00, 8'h00, 1);
      nack_at = 0;
      stretch_ns = 400000;
      run_cmd(1, 1, 16'h0077, 8'h11, 8'h00, 1);
      stretch_ns = 0;
      #150000;
      busy_polls = 255;
      run_cmd(1, 1, 16'h0042, 8'h99, 8'h00, 1);
      #50000;
      cmp_byte("rd_left", 8'h00, 8'(exp_rd.size()));
      cmp_flag("scl_released", 1'b1, o_scl_oe_n);
      cmp_flag("sda_released", 1'b1, o_sda_oe_n);
      cmp_flag("cmd_ready", 1'b1, o_cmd_ready);
      cmp_flag("scl_level", 1'b0, o_scl);
      cmp_flag("sda_level", 1'b0, o_sda);
      complete_run();
   end
endmodule
